// ===== design/io_mon_defines.svh
`ifndef IO_MON_DEFINES_SVH
`define IO_MON_DEFINES_SVH

`define NUM_ELEM      23
`define E_DIN1        5'd0
`define E_DIN2        5'd1
`define E_DIGITAL_INPUT_THREE        5'd2
`define E_AIN         5'd3
`define E_GSM         5'd4
`define E_MODE        5'd5
`define E_TEMP        5'd6
`define E_DOUT1       5'd7
`define E_DOUT2       5'd8
`define E_PDOP        5'd9
`define E_HDOP        5'd10
`define E_ODO         5'd11
`define E_SLEEP       5'd12
`define E_MOTION      5'd13
`define E_ZONE0       5'd14
`define NUM_ZONES     6
`define E_TRIP        5'd20
`define E_ECO_TYPE    5'd21
`define E_ECO_VAL     5'd22
`define E_LAST        5'd22

`define BYTES_ONE     4'd1
`define BYTES_WORD    4'd2
`define BYTES_LONG    4'd4
`define GPS_BYTES     15
`define GPS_LAST      4'd14

`define AIN_MAX_MV    16'h7530
`define GSM_MIN       3'h1
`define GSM_MAX       3'h5
`define TEMP_ERR_CODE 32'h00000bb8
`define TEMP_SCALE    32'sh0000000a
`define DOP_MAX       16'h01f4
`define SLEEP_NONE    32'h0
`define SLEEP_GPS     32'h1
`define SLEEP_DEEP    32'h2
`define MODE_HOME     2'h0
`define MODE_ROAM     2'h1
`define MODE_UNKNOWN  2'h2
`define MOVE_TMO_MIN  32'h1
`define MOVE_TMO_MAX  32'h3b

`define CLK_PERIOD_NS 10
`define AVG_TICK_NS   30000000
`define SEC_NS        1000000000
`define AVG_TICK_CYC  (`AVG_TICK_NS / `CLK_PERIOD_NS)
`define SEC_CYC       (`SEC_NS / `CLK_PERIOD_NS)

`endif

// ===== design/io_mon_pkg.sv
package io_mon_pkg;
  typedef enum logic [1:0] {PRIO_LOW, PRIO_HIGH, PRIO_PANIC} prio_t;
  typedef enum logic [1:0] {SEL_MONITOR, SEL_ENTER, SEL_EXIT, SEL_BOTH} evsel_t;
endpackage

// ===== design/element_filter_if.sv
`timescale 1ns/1ps
`default_nettype none
interface element_filter_if;
  logic                   enable;
  logic                   is_signed;
  logic                   deep_sleep;
  logic                   tick;
  logic [31:0]            value;
  logic [31:0]            low;
  logic [31:0]            high;
  logic [31:0]            avg;
  io_mon_pkg::evsel_t     sel;
  logic                   event_pulse;
  logic                   stable_in;
  modport main (output enable, is_signed, deep_sleep, tick, value, low, high, avg, sel,
                input event_pulse, stable_in);
  modport filter (input enable, is_signed, deep_sleep, tick, value, low, high, avg, sel,
                  output event_pulse, stable_in);
endinterface
`default_nettype wire

// ===== design/element_event_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "io_mon_defines.svh"
module element_event_filter #(
  parameter bit MOTION = 1'b0
) (
  input wire logic          clk_sys,
  input wire logic          rst_b,
  element_filter_if.filter  f
);
  logic        in_range;
  logic        hit;
  logic [31:0] req;
  logic [31:0] cnt_q;
  logic        stable_q;
  logic        event_q;

  always_comb begin
    if (f.is_signed) begin
      in_range = ($signed(f.value) >= $signed(f.low)) && ($signed(f.value) <= $signed(f.high));
    end else begin
      in_range = (f.value >= f.low) && (f.value <= f.high);
    end
  end

  // motion counts seconds, clamped to the legal timeout span
  always_comb begin
    req = f.avg;
    if (MOTION && (f.avg < `MOVE_TMO_MIN)) begin
      req = `MOVE_TMO_MIN;
    end else if (MOTION && (f.avg > `MOVE_TMO_MAX)) begin
      req = `MOVE_TMO_MAX;
    end
  end

  always_comb begin
    hit = (f.sel == io_mon_pkg::SEL_BOTH) ||
          ((f.sel == io_mon_pkg::SEL_ENTER) && in_range) ||
          ((f.sel == io_mon_pkg::SEL_EXIT) && !in_range);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q    <= 32'h0;
      stable_q <= 1'b0;
      event_q  <= 1'b0;
    end else if (!f.enable) begin
      // disabled elements track silently so enabling raises no stale event
      cnt_q    <= 32'h0;
      stable_q <= in_range;
      event_q  <= 1'b0;
    end else if (in_range == stable_q) begin
      cnt_q   <= 32'h0;
      event_q <= 1'b0;
    end else if (f.deep_sleep || (cnt_q >= req)) begin
      cnt_q    <= 32'h0;
      stable_q <= in_range;
      event_q  <= hit;
    end else begin
      cnt_q   <= f.tick ? cnt_q + 32'h1 : cnt_q;
      event_q <= 1'b0;
    end
  end

  assign f.event_pulse = event_q;
  assign f.stable_in   = stable_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_RANGE_RESTART: assert property (f.enable && (in_range == stable_q) |=> cnt_q == 32'h0)
    else $error("averaging count not restarted");
  AST_EVENT_MATCHES_SEL: assert property (event_q |-> $past(hit) && $past(f.enable))
    else $error("event does not match selection");
  AST_AVG_HELD: assert property (f.enable && !f.deep_sleep && (in_range != stable_q) && (cnt_q < req) |=>
                                 stable_q == $past(stable_q))
    else $error("crossing accepted before averaging ended");
  COV_FILTER_EVENT: cover property (event_q);
endmodule // element_event_filter
`default_nettype wire

// ===== design/io_element_event_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "io_mon_defines.svh"
module io_element_event_monitor #(
  parameter int AVG_TICK_CYCLES = `AVG_TICK_CYC,
  parameter int SEC_TICK_CYCLES = `SEC_CYC
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_b,
  input  wire logic [`NUM_ELEM-1:0]        elem_enable,
  input  wire io_mon_pkg::prio_t           elem_prio [`NUM_ELEM],
  input  wire io_mon_pkg::evsel_t          elem_sel [`NUM_ELEM],
  input  wire logic [31:0]                 elem_low [`NUM_ELEM],
  input  wire logic [31:0]                 elem_high [`NUM_ELEM],
  input  wire logic [31:0]                 elem_avg [`NUM_ELEM],
  input  wire logic                        sms_enable,
  input  wire logic                        record_req,
  input  wire logic                        upload_ok,
  input  wire logic                        upload_fail,
  input  wire logic [`GPS_BYTES*8-1:0]     gps_data,
  input  wire logic [1:0]                  digital_input_pin,
  input  wire logic                        digital_input_three,
  input  wire logic                        motion_pin,
  input  wire logic [1:0]                  dout_state,
  input  wire logic [15:0]                 ain_mv,
  input  wire logic [2:0]                  gsm_level,
  input  wire logic                        net_known,
  input  wire logic                        roaming,
  input  wire logic signed [7:0]           temp_c,
  input  wire logic                        temp_err,
  input  wire logic [15:0]                 pdop_x10,
  input  wire logic [15:0]                 hdop_x10,
  input  wire logic                        odo_step_valid,
  input  wire logic [15:0]                 odo_step_m,
  input  wire logic                        gps_sleep,
  input  wire logic                        deep_sleep,
  input  wire logic [`NUM_ZONES-1:0]       zone_inside,
  input  wire logic                        journey_active,
  input  wire logic [1:0]                  eco_type,
  input  wire logic [7:0]                  eco_value,
  output logic [7:0]                       rec_byte_q,
  output logic                             rec_byte_valid_q,
  output logic                             rec_end_q,
  output logic                             rec_is_event_q,
  output logic [4:0]                       rec_elem_q,
  output io_mon_pkg::prio_t                rec_prio_q,
  output logic                             upload_now_q,
  output logic                             sms_send_q
);
  typedef enum logic [1:0] {ST_IDLE, ST_GPS, ST_ELEM, ST_END} rec_state_t;

  rec_state_t             state_q;
  logic [3:0]             pin_s1_q;
  logic [3:0]             pin_s2_q;
  logic [3:0]             pin_s3_q;
  logic [3:0]             pin_f_q;
  logic [31:0]            avg_cnt_q;
  logic [31:0]            sec_cnt_q;
  logic                   avg_tick_q;
  logic                   sec_tick_q;
  logic [31:0]            odo_q;
  logic [31:0]            elem_val [`NUM_ELEM];
  logic [`NUM_ELEM-1:0]   ev;
  logic [`NUM_ELEM-1:0]   pend_q;
  logic [`NUM_ELEM-1:0]   pend_clr;
  logic                   req_pend_q;
  logic                   ev_any;
  logic [4:0]             ev_idx;
  logic [4:0]             elem_idx_q;
  logic [3:0]             byte_idx_q;
  logic [3:0]             cur_w;
  logic [3:0]             rev_idx;
  logic [31:0]            cur_shift;
  logic [`GPS_BYTES*8-1:0] gps_shift;
  logic                   last_panic_q;
  logic                   start;

  function automatic logic [3:0] elem_bytes(input logic [4:0] idx);
    case (idx)
      `E_AIN, `E_PDOP, `E_HDOP: elem_bytes = `BYTES_WORD;
      `E_TEMP, `E_ODO:          elem_bytes = `BYTES_LONG;
      default:                  elem_bytes = `BYTES_ONE;
    endcase
  endfunction

  // pins: a change counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      pin_s3_q <= 4'h0;
      pin_f_q  <= 4'h0;
    end else begin
      pin_s1_q <= {motion_pin, digital_input_three, digital_input_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q  <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avg_cnt_q  <= 32'h0;
      sec_cnt_q  <= 32'h0;
      avg_tick_q <= 1'b0;
      sec_tick_q <= 1'b0;
    end else begin
      avg_tick_q <= (avg_cnt_q == 32'(AVG_TICK_CYCLES - 1));
      avg_cnt_q  <= (avg_cnt_q == 32'(AVG_TICK_CYCLES - 1)) ? 32'h0 : avg_cnt_q + 32'h1;
      sec_tick_q <= (sec_cnt_q == 32'(SEC_TICK_CYCLES - 1));
      sec_cnt_q  <= (sec_cnt_q == 32'(SEC_TICK_CYCLES - 1)) ? 32'h0 : sec_cnt_q + 32'h1;
    end
  end

  // a step landing in the record's last cycle starts the next distance
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      odo_q <= 32'h0;
    end else if (state_q == ST_END) begin
      odo_q <= odo_step_valid ? 32'(odo_step_m) : 32'h0;
    end else if (odo_step_valid) begin
      odo_q <= odo_q + 32'(odo_step_m);
    end
  end

  always_comb begin
    for (int i = 0; i < `NUM_ELEM; i++) begin
      elem_val[i] = 32'h0;
    end
    elem_val[`E_DIN1]   = 32'(pin_f_q[0]);
    elem_val[`E_DIN2]   = 32'(pin_f_q[1]);
    elem_val[`E_DIGITAL_INPUT_THREE]   = 32'(pin_f_q[2]);
    elem_val[`E_DOUT1]  = 32'(dout_state[0]);
    elem_val[`E_DOUT2]  = 32'(dout_state[1]);
    elem_val[`E_AIN]    = 32'((ain_mv > `AIN_MAX_MV) ? `AIN_MAX_MV : ain_mv);
    elem_val[`E_GSM]    = 32'((gsm_level < `GSM_MIN) ? `GSM_MIN :
                              ((gsm_level > `GSM_MAX) ? `GSM_MAX : gsm_level));
    elem_val[`E_MODE]   = 32'({(!net_known ? `MODE_UNKNOWN : (roaming ? `MODE_ROAM : `MODE_HOME)),
                               pin_f_q[3]});
    elem_val[`E_TEMP]   = temp_err ? `TEMP_ERR_CODE :
                          32'($signed({{24{temp_c[7]}}, temp_c}) * `TEMP_SCALE);
    elem_val[`E_PDOP]   = 32'((pdop_x10 > `DOP_MAX) ? `DOP_MAX : pdop_x10);
    elem_val[`E_HDOP]   = 32'((hdop_x10 > `DOP_MAX) ? `DOP_MAX : hdop_x10);
    elem_val[`E_ODO]    = odo_q;
    elem_val[`E_SLEEP]  = deep_sleep ? `SLEEP_DEEP : (gps_sleep ? `SLEEP_GPS : `SLEEP_NONE);
    elem_val[`E_MOTION] = 32'(pin_f_q[3]);
    for (int z = 0; z < `NUM_ZONES; z++) begin
      elem_val[`E_ZONE0 + 5'(z)] = 32'(zone_inside[z]);
    end
    elem_val[`E_TRIP]     = 32'(journey_active);
    elem_val[`E_ECO_TYPE] = 32'(eco_type);
    elem_val[`E_ECO_VAL]  = 32'(eco_value);
  end

  genvar g;
  generate
    for (g = 0; g < `NUM_ELEM; g++) begin : gen_elem
      element_filter_if fif ();
      assign fif.enable     = elem_enable[g];
      assign fif.is_signed  = (g == `E_TEMP);
      assign fif.deep_sleep = deep_sleep;
      assign fif.tick       = (g == `E_MOTION) ? sec_tick_q : avg_tick_q;
      assign fif.value      = elem_val[g];
      assign fif.low        = elem_low[g];
      assign fif.high       = elem_high[g];
      assign fif.avg        = elem_avg[g];
      assign fif.sel        = elem_sel[g];
      assign ev[g]          = fif.event_pulse && (elem_sel[g] != io_mon_pkg::SEL_MONITOR);
      element_event_filter #(.MOTION(g == `E_MOTION)) u_filter (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .f       (fif.filter)
      );
    end
  endgenerate

  always_comb begin
    ev_any = |pend_q;
    ev_idx = 5'h0;
    for (int i = `NUM_ELEM - 1; i >= 0; i--) begin
      if (pend_q[i]) begin
        ev_idx = 5'(i);
      end
    end
  end

  assign start = (state_q == ST_IDLE) && (ev_any || req_pend_q);

  always_comb begin
    pend_clr = '0;
    if ((state_q == ST_IDLE) && ev_any) begin
      pend_clr[ev_idx] = 1'b1;
    end
  end

  // set wins over clear so a fresh event is never lost
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend_q     <= '0;
      req_pend_q <= 1'b0;
    end else begin
      pend_q     <= (pend_q & ~pend_clr) | ev;
      req_pend_q <= (req_pend_q & ~(start && !ev_any)) | record_req;
    end
  end

  always_comb begin
    cur_w     = elem_bytes(elem_idx_q);
    rev_idx   = cur_w - 4'h1 - byte_idx_q;
    cur_shift = elem_val[elem_idx_q] >> {rev_idx[1:0], 3'b000};
    gps_shift = gps_data >> {(`GPS_LAST - byte_idx_q), 3'b000};
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q          <= ST_IDLE;
      elem_idx_q       <= 5'h0;
      byte_idx_q       <= 4'h0;
      rec_byte_q       <= 8'h0;
      rec_byte_valid_q <= 1'b0;
      rec_end_q        <= 1'b0;
      upload_now_q     <= 1'b0;
      rec_is_event_q   <= 1'b0;
      rec_elem_q       <= 5'h0;
      rec_prio_q       <= io_mon_pkg::PRIO_LOW;
    end else begin
      rec_byte_valid_q <= 1'b0;
      rec_end_q        <= 1'b0;
      upload_now_q     <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q        <= ST_GPS;
            byte_idx_q     <= 4'h0;
            rec_is_event_q <= ev_any;
            rec_elem_q     <= ev_any ? ev_idx : 5'h0;
            rec_prio_q     <= ev_any ? elem_prio[ev_idx] : io_mon_pkg::PRIO_LOW;
          end
        end
        ST_GPS: begin
          rec_byte_q       <= gps_shift[7:0];
          rec_byte_valid_q <= 1'b1;
          byte_idx_q       <= byte_idx_q + 4'h1;
          if (byte_idx_q == `GPS_LAST) begin
            state_q    <= ST_ELEM;
            elem_idx_q <= 5'h0;
            byte_idx_q <= 4'h0;
          end
        end
        ST_ELEM: begin
          // a disabled element costs one idle cycle and adds nothing
          if (elem_enable[elem_idx_q]) begin
            rec_byte_q       <= cur_shift[7:0];
            rec_byte_valid_q <= 1'b1;
          end
          if (!elem_enable[elem_idx_q] || (byte_idx_q == cur_w - 4'h1)) begin
            byte_idx_q <= 4'h0;
            elem_idx_q <= elem_idx_q + 5'h1;
            if (elem_idx_q == `E_LAST) begin
              state_q <= ST_END;
            end
          end else begin
            byte_idx_q <= byte_idx_q + 4'h1;
          end
        end
        ST_END: begin
          state_q      <= ST_IDLE;
          rec_end_q    <= 1'b1;
          upload_now_q <= rec_is_event_q && (rec_prio_q != io_mon_pkg::PRIO_LOW);
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // the text path only backs up the packet link for panic records
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      last_panic_q <= 1'b0;
      sms_send_q   <= 1'b0;
    end else begin
      sms_send_q <= upload_fail && last_panic_q && sms_enable;
      if (upload_now_q) begin
        last_panic_q <= (rec_prio_q == io_mon_pkg::PRIO_PANIC);
      end else if (upload_ok || upload_fail) begin
        last_panic_q <= 1'b0;
      end
    end
  end

  logic [7:0] ast_bytes_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ast_bytes_q <= 8'h0;
    end else if (rec_end_q) begin
      ast_bytes_q <= 8'h0;
    end else if (rec_byte_valid_q) begin
      ast_bytes_q <= ast_bytes_q + 8'h1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  AST_GPS_ONLY: assert property (rec_end_q && (elem_enable == '0) |-> ast_bytes_q == 8'(`GPS_BYTES))
    else $error("record with no elements is not positioning only");
  AST_AIN_SPAN: assert property (elem_val[`E_AIN] <= 32'(`AIN_MAX_MV))
    else $error("analog value out of span");
  AST_GSM_SCALE: assert property (elem_val[`E_GSM] >= 32'(`GSM_MIN) && elem_val[`E_GSM] <= 32'(`GSM_MAX))
    else $error("signal level out of scale");
  AST_TEMP_ERR: assert property (temp_err |-> elem_val[`E_TEMP] == `TEMP_ERR_CODE)
    else $error("sensor error code missing");
  AST_DOP_MAX: assert property (elem_val[`E_PDOP] <= 32'(`DOP_MAX) && elem_val[`E_HDOP] <= 32'(`DOP_MAX))
    else $error("dilution value above limit");
  AST_LOW_NO_UPLOAD: assert property (rec_end_q && (rec_prio_q == io_mon_pkg::PRIO_LOW) |-> !upload_now_q)
    else $error("low priority record uploaded");
  AST_HIGH_UPLOAD: assert property (start && ev_any && (elem_prio[ev_idx] != io_mon_pkg::PRIO_LOW)
                                    |-> ##[1:60] (rec_end_q && upload_now_q))
    else $error("urgent record not uploaded");
  AST_SMS_FALLBACK: assert property (upload_fail && last_panic_q && sms_enable |=> sms_send_q)
    else $error("panic fallback not sent");

  COV_EVENT_RECORD: cover property (rec_end_q && rec_is_event_q);
  COV_PANIC_SMS: cover property (sms_send_q);
  COV_GPS_ONLY: cover property (rec_end_q && (elem_enable == '0));
endmodule // io_element_event_monitor
`default_nettype wire

// ===== verif/track_server_model.sv
`timescale 1ns/1ps
`default_nettype none
module track_server_model #(
  parameter int DELAY = 3
) (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic upload_now_q,
  input  wire logic fail_mode,
  output logic      upload_ok,
  output logic      upload_fail
);
  int wait_q;
  // a link never answers in the request cycle, so replies lag the request by DELAY+1 cycles
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wait_q      <= 0;
      upload_ok   <= 1'b0;
      upload_fail <= 1'b0;
    end else begin
      upload_ok   <= (wait_q == 1) && !fail_mode;
      upload_fail <= (wait_q == 1) && fail_mode;
      if (upload_now_q) wait_q <= DELAY;
      else if (wait_q != 0) wait_q <= wait_q - 1;
    end
  end
endmodule // track_server_model
`default_nettype wire

// ===== verif/io_element_event_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "io_mon_defines.svh"
`define CHK(got, exp, msg) begin check_count++; if ((got) !== (exp)) begin mismatches++; $display("BAD %0t %s", $time, msg); end end
module io_element_event_monitor_tb;
  typedef struct {int idx; logic [31:0] v; int n; logic [31:0] e;} row_t;
  logic clk_sys = 1'b0, rst_b = 1'b0, sms_enable, record_req, fail_mode;
  logic [`NUM_ELEM-1:0] elem_enable;
  io_mon_pkg::prio_t    elem_prio [`NUM_ELEM];
  io_mon_pkg::evsel_t   elem_sel [`NUM_ELEM];
  logic [31:0]          elem_low [`NUM_ELEM], elem_high [`NUM_ELEM], elem_avg [`NUM_ELEM];
  logic upload_ok, upload_fail, digital_input_three, motion_pin, net_known, roaming, temp_err;
  logic odo_step_valid, gps_sleep, deep_sleep, journey_active;
  logic [119:0] gps_data = 120'h0102030405060708090a0b0c0d0e0f;
  logic [1:0]  digital_input_pin, dout_state, eco_type;
  logic [15:0] ain_mv, pdop_x10, hdop_x10, odo_step_m;
  logic [2:0]  gsm_level;
  logic signed [7:0] temp_c;
  logic [5:0]  zone_inside;
  logic [7:0]  eco_value, rec_byte_q;
  logic rec_byte_valid_q, rec_end_q, rec_is_event_q, upload_now_q, sms_send_q, up_seen, seen;
  logic [4:0]  rec_elem_q;
  io_mon_pkg::prio_t rec_prio_q;
  logic [7:0]  rec_q [$];
  int mismatches = 0, check_count = 0, cyc;
  row_t rows [17] = '{
    '{3, 40000, 2, 32'h7530},
    '{4, 3, 1, 32'h3},
    '{4, 7, 1, 32'h5},
    '{5, 1, 1, 32'h0},
    '{5, 3, 1, 32'h2},
    '{5, 0, 1, 32'h4},
    '{6, 32'hfb, 4, 32'hffffffce},
    '{6, 32'h100, 4, 32'hbb8},
    '{7, 1, 1, 32'h1},
    '{9, 600, 2, 32'h1f4},
    '{10, 250, 2, 32'hfa},
    '{14, 1, 1, 32'h1},
    '{20, 1, 1, 32'h1},
    '{21, 3, 1, 32'h3},
    '{22, 123, 1, 32'h7b},
    '{12, 2, 1, 32'h2},
    '{12, 1, 1, 32'h1}};
  always #5 clk_sys = ~clk_sys;
  io_element_event_monitor #(.AVG_TICK_CYCLES(4), .SEC_TICK_CYCLES(8)) io_element_event_monitor_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .elem_enable(elem_enable), .elem_prio(elem_prio),
    .elem_sel(elem_sel), .elem_low(elem_low), .elem_high(elem_high), .elem_avg(elem_avg),
    .sms_enable(sms_enable), .record_req(record_req), .upload_ok(upload_ok), .upload_fail(upload_fail),
    .gps_data(gps_data), .digital_input_pin(digital_input_pin), .digital_input_three(digital_input_three),
    .motion_pin(motion_pin), .dout_state(dout_state), .ain_mv(ain_mv), .gsm_level(gsm_level),
    .net_known(net_known), .roaming(roaming), .temp_c(temp_c), .temp_err(temp_err), .pdop_x10(pdop_x10),
    .hdop_x10(hdop_x10), .odo_step_valid(odo_step_valid), .odo_step_m(odo_step_m), .gps_sleep(gps_sleep),
    .deep_sleep(deep_sleep), .zone_inside(zone_inside), .journey_active(journey_active), .eco_type(eco_type),
    .eco_value(eco_value), .rec_byte_q(rec_byte_q), .rec_byte_valid_q(rec_byte_valid_q), .rec_end_q(rec_end_q),
    .rec_is_event_q(rec_is_event_q), .rec_elem_q(rec_elem_q), .rec_prio_q(rec_prio_q),
    .upload_now_q(upload_now_q), .sms_send_q(sms_send_q));
  track_server_model track_server_model_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .upload_now_q(upload_now_q), .fail_mode(fail_mode),
    .upload_ok(upload_ok), .upload_fail(upload_fail));
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic drive(input int idx, input logic [31:0] v);
    case (idx)
      3: ain_mv <= v[15:0];
      4: gsm_level <= v[2:0];
      5: {roaming, net_known} <= v[1:0];
      6: {temp_err, temp_c} <= v[8:0];
      7: dout_state <= v[1:0];
      9: pdop_x10 <= v[15:0];
      10: hdop_x10 <= v[15:0];
      12: {deep_sleep, gps_sleep} <= v[1:0];
      14: zone_inside <= v[5:0];
      20: journey_active <= v[0];
      21: eco_type <= v[1:0];
      default: eco_value <= v[7:0];
    endcase
  endtask
  // cyc counts the cycles spent before the first byte, used to bound event latency
  task automatic collect();
    rec_q.delete();
    cyc = 0;
    for (int n = 0; n < 600; n++) begin
      @(posedge clk_sys);
      #1;
      if (rec_byte_valid_q === 1'b1) rec_q.push_back(rec_byte_q);
      if (rec_q.size() == 0) cyc++;
      if (rec_end_q === 1'b1) begin
        up_seen = upload_now_q;
        return;
      end
    end
    mismatches++;
    $display("BAD %0t record timeout", $time);
    close_out();
  endtask
  task automatic request();
    @(posedge clk_sys);
    record_req <= 1'b1;
    @(posedge clk_sys);
    record_req <= 1'b0;
    collect();
  endtask
  initial begin
    {sms_enable, record_req, fail_mode, digital_input_three, motion_pin, net_known, roaming} = '0;
    {temp_err, odo_step_valid, gps_sleep, deep_sleep, journey_active, elem_enable} = '0;
    {digital_input_pin, dout_state, eco_type, ain_mv, pdop_x10, hdop_x10, odo_step_m} = '0;
    {gsm_level, temp_c, zone_inside, eco_value} = '0;
    for (int i = 0; i < `NUM_ELEM; i++) begin
      elem_prio[i] = io_mon_pkg::PRIO_LOW;
      elem_sel[i] = io_mon_pkg::SEL_MONITOR;
      {elem_low[i], elem_high[i], elem_avg[i]} = '0;
    end
    repeat (2) @(posedge clk_sys);
    `CHK({rec_byte_valid_q, rec_end_q, upload_now_q, sms_send_q}, 4'h0, "reset outputs");
    rst_b <= 1'b1;
    request();
    `CHK(rec_q.size(), 15, "plain length");
    for (int k = 0; k < 15; k++) `CHK(rec_q[k], gps_data[119-8*k -: 8], "gps byte");
    $display("test reset done");
    for (int i = 0; i < 17; i++) begin
      @(posedge clk_sys);
      elem_enable <= `NUM_ELEM'(1) << rows[i].idx;
      drive(rows[i].idx, rows[i].v);
      repeat (4) @(posedge clk_sys);
      request();
      `CHK(rec_q.size(), 15 + rows[i].n, "row length");
      for (int k = 0; k < rows[i].n; k++) `CHK(rec_q[15+k], rows[i].e[8*(rows[i].n-1-k) +: 8], "row byte");
    end
    $display("test rows done");
    // din1 enters [1,1]; the sync stages alone are shorter than the averaging wait
    @(posedge clk_sys);
    {deep_sleep, gps_sleep} <= 2'h0;
    elem_enable <= `NUM_ELEM'(1);
    elem_sel[0] <= io_mon_pkg::SEL_ENTER;
    {elem_low[0], elem_high[0], elem_avg[0]} <= {32'h1, 32'h1, 32'h3};
    repeat (20) @(posedge clk_sys);
    digital_input_pin <= 2'h1;
    collect();
    `CHK(cyc >= 9, 1'b1, "event too early");
    `CHK({rec_is_event_q, rec_elem_q, up_seen}, 7'h40, "low event header");
    `CHK(rec_prio_q, io_mon_pkg::PRIO_LOW, "low prio");
    `CHK(rec_q[15], 8'h01, "din byte");
    $display("test low event done");
    @(posedge clk_sys);
    gsm_level <= 3'h2;
    repeat (30) @(posedge clk_sys);
    elem_enable <= `NUM_ELEM'(1) << 4;
    elem_sel[4] <= io_mon_pkg::SEL_BOTH;
    elem_prio[4] <= io_mon_pkg::PRIO_HIGH;
    {elem_low[4], elem_high[4], elem_avg[4]} <= {32'h4, 32'h5, 32'h1};
    repeat (20) @(posedge clk_sys);
    gsm_level <= 3'h5;
    collect();
    `CHK({rec_is_event_q, rec_elem_q, up_seen}, 7'h49, "enter event header");
    `CHK(rec_prio_q, io_mon_pkg::PRIO_HIGH, "high prio");
    `CHK(rec_q[15], 8'h05, "gsm byte");
    $display("test high event done");
    @(posedge clk_sys);
    elem_prio[4] <= io_mon_pkg::PRIO_PANIC;
    {sms_enable, fail_mode} <= 2'h3;
    gsm_level <= 3'h1;
    collect();
    `CHK({rec_is_event_q, up_seen}, 2'h3, "exit event upload");
    `CHK(rec_prio_q, io_mon_pkg::PRIO_PANIC, "panic prio");
    seen = 1'b0;
    for (int n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      #1;
      if (sms_send_q === 1'b1) seen = 1'b1;
    end
    `CHK(seen, 1'b1, "text fallback");
    $display("test panic done");
    // one distance step before the record must show up as a four byte total
    @(posedge clk_sys);
    elem_enable <= `NUM_ELEM'(1) << 11;
    {odo_step_valid, odo_step_m} <= {1'b1, 16'h0064};
    @(posedge clk_sys);
    odo_step_valid <= 1'b0;
    request();
    `CHK(rec_q.size(), 19, "odo length");
    `CHK({rec_q[15], rec_q[16], rec_q[17], rec_q[18]}, 32'h00000064, "odo value");
    $display("test odometer done");
    // a long averaging wait would time out unless deep sleep skips it
    @(posedge clk_sys);
    elem_enable <= `NUM_ELEM'(1) << 3;
    elem_sel[3] <= io_mon_pkg::SEL_ENTER;
    {elem_low[3], elem_high[3], elem_avg[3]} <= {32'h3e8, 32'h7d0, 32'h100};
    repeat (4) @(posedge clk_sys);
    {deep_sleep, ain_mv} <= {1'b1, 16'h05dc};
    collect();
    `CHK(cyc < 8, 1'b1, "deep sleep averaging");
    `CHK({rec_is_event_q, rec_elem_q}, 6'h23, "deep event header");
    $display("test deep sleep done");
    close_out();
  end
endmodule // io_element_event_monitor_tb
`default_nettype wire
